// ### src/gcl_clk_div.v
// Aux clock divider: toggles the pin every half_cycles system cycles.
// Assumes half_cycles is at least 2 and enable comes from the same clock.
`timescale 1ns/1ps
module gcl_clk_div #(
  parameter CNT_W = 8
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Control
  input wire enable,
  input wire [CNT_W-1:0] half_cycles,
  // Divided clock
  output reg clk_out
);

  reg [CNT_W-1:0] count; // Cycles into the current half period

  // Counter and toggle; a rate change applies to the half period already in progress
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= {CNT_W{1'b0}};
      clk_out <= 1'b0;
    end else if (!enable) begin
      // Idle low so a restart begins with a clean full half period
      count <= {CNT_W{1'b0}};
      clk_out <= 1'b0;
    end else if (count >= half_cycles - {{(CNT_W-1){1'b0}}, 1'b1}) begin
      count <= {CNT_W{1'b0}};
      clk_out <= ~clk_out;
    end else begin
      count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ### src/gcl_config.v
// General configuration low field logic: register, aux clock, path
// selects, clear routing, link diag quiet masking and oscillator watch.
// Assumes error flags and clear requests come from logic on clk_sys and
// the oscillator tick arrives from another domain.
// Register reads answer one cycle after the strobe and never stall.
// Reserved bits 1:0 are stored as written; the host keeps them zero.
//
// How it works
// - Bits 9:7 pick aux clock rate, reset 100
// - Aux clock runs only while config field is 01
// - Bit 6 joins coupling pin path to output
// - Bit 5 shifts only unipolar 6V/12V ranges down
// - Bit 4 makes clear skip the slew ramp
// - Quiet bit drops link errors from summary
// - Quiet bit keeps link errors off fault pin
// - Bit 2 watches oscillator, forces fixed code
//
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`include "gcl_defs.vh"
module gcl_config #(
  parameter OTHER_W = 4,
  parameter OSC_TIMEOUT = `GCL_OSC_TIMEOUT_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire resetn,
  // Register port
  input wire [4:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [23:0] reg_rdata,
  // Aux clock pin
  output wire aux_clock_pin,
  // Output path controls
  output reg modem_path_on,
  output reg below_zero_shift_on,
  output reg [9:0] offset_mv,
  input wire range_uni6,
  input wire range_uni12,
  // Clear routing
  input wire clear_req,
  output reg clear_immediate,
  output reg clear_slewed,
  // Link error flags and other diagnostics
  input wire link_check_err,
  input wire frame_slip_err,
  input wire edge_count_err,
  input wire [OTHER_W-1:0] other_diag_err,
  input wire analog_fault,
  output reg digital_diag_summary,
  output reg fault_pin_n,
  // Temperature threshold select, passed to the comparator
  output reg [1:0] temp_threshold_sel,
  // Oscillator watch and serial data override
  input wire osc_tick,
  output reg sdo_force_dead,
  output reg [23:0] sdo_dead_code
);

  // Timeout counter width, enough for any sensible timeout
  localparam OSC_W = 13;
  // Timeout cut to the counter width on purpose; larger values wrap
  localparam [31:0] OSC_LIMIT_W = OSC_TIMEOUT;
  localparam [OSC_W-1:0] OSC_LIMIT = OSC_LIMIT_W[OSC_W-1:0];

  // Half periods per rate code, worked out at full integer width
  // Nearest-cycle rounding keeps every rate within one percent
  localparam [31:0] HALF_W0 = `GCL_HALF_CYC(`GCL_RATE0_KHZ);
  localparam [31:0] HALF_W1 = `GCL_HALF_CYC(`GCL_RATE1_KHZ);
  localparam [31:0] HALF_W2 = `GCL_HALF_CYC(`GCL_RATE2_KHZ);
  localparam [31:0] HALF_W3 = `GCL_HALF_CYC(`GCL_RATE3_KHZ);
  localparam [31:0] HALF_W4 = `GCL_HALF_CYC(`GCL_RATE4_KHZ);
  localparam [31:0] HALF_W5 = `GCL_HALF_CYC(`GCL_RATE5_KHZ);
  localparam [31:0] HALF_W6 = `GCL_HALF_CYC(`GCL_RATE6_KHZ);
  localparam [31:0] HALF_W7 = `GCL_HALF_CYC(`GCL_RATE7_KHZ);

  // Stored fields of the configuration register
  reg [1:0] aux_clock_out_cfg;
  reg [2:0] aux_clock_rate_sel;
  reg immediate_clear_on;
  reg link_diag_quiet_on;
  reg osc_halt_watch_on;
  reg [1:0] rsvd_low; // Written by host, read back as is

  // Combinational helpers
  reg [7:0] half_cycles; // Half period of the selected rate
  wire aux_run; // Aux clock allowed to toggle
  wire link_err_any; // OR of the three link errors
  wire link_err_vis; // Link errors after quiet masking
  wire next_summary; // Digital diag summary before the flop
  wire next_fault; // Fault condition before the flop
  wire cfg_hit; // Access aimed at the config register
  wire stat_hit; // Access aimed at the status register
  wire [23:0] cfg_word; // Config register as read
  wire [23:0] stat_word; // Status register as read

  // Oscillator watch state
  reg osc_sync1; // First synchroniser stage
  reg osc_sync2; // Second synchroniser stage
  reg osc_prev; // Last synchronised level, for edge detect
  reg [OSC_W-1:0] osc_idle; // Cycles since last oscillator edge
  reg osc_halted; // Oscillator judged stopped

  // Address decode
  assign cfg_hit = (reg_addr == `GCL_ADDR_CONFIG);
  assign stat_hit = (reg_addr == `GCL_ADDR_STATUS);

  // Config register writes; read-only fields are not stored
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      temp_threshold_sel <= `GCL_RST_TEMP;
      aux_clock_out_cfg <= `GCL_RST_AUXCFG;
      aux_clock_rate_sel <= `GCL_RST_RATE;
      modem_path_on <= `GCL_RST_MODEM;
      below_zero_shift_on <= `GCL_RST_SHIFT;
      immediate_clear_on <= `GCL_RST_CLRNOW;
      link_diag_quiet_on <= `GCL_RST_QUIET;
      osc_halt_watch_on <= `GCL_RST_OSCW;
      rsvd_low <= `GCL_RST_RSVD;
    end else if (reg_wr && cfg_hit) begin
      // Threshold select only passes through to the comparator
      temp_threshold_sel <= reg_wdata[`GCL_TEMP_HI:`GCL_TEMP_LO];
      aux_clock_out_cfg <= reg_wdata[`GCL_AUXCFG_HI:`GCL_AUXCFG_LO];
      aux_clock_rate_sel <= reg_wdata[`GCL_RATE_HI:`GCL_RATE_LO];
      // Path select drives the output stage switch directly
      modem_path_on <= reg_wdata[`GCL_MODEM_BIT];
      below_zero_shift_on <= reg_wdata[`GCL_SHIFT_BIT];
      immediate_clear_on <= reg_wdata[`GCL_CLRNOW_BIT];
      link_diag_quiet_on <= reg_wdata[`GCL_QUIET_BIT];
      osc_halt_watch_on <= reg_wdata[`GCL_OSCW_BIT];
      // Stored untouched; the host is trusted to leave them zero
      rsvd_low <= reg_wdata[`GCL_RSVD_HI:`GCL_RSVD_LO];
    end
  end

  // Rate select to half period, rounded to the nearest cycle
  always @* begin
    half_cycles = 8'h7D;
    case (aux_clock_rate_sel)
      3'h0: half_cycles = HALF_W0[7:0];
      3'h1: half_cycles = HALF_W1[7:0];
      3'h2: half_cycles = HALF_W2[7:0];
      3'h3: half_cycles = HALF_W3[7:0];
      3'h4: half_cycles = HALF_W4[7:0];
      3'h5: half_cycles = HALF_W5[7:0];
      3'h6: half_cycles = HALF_W6[7:0];
      3'h7: half_cycles = HALF_W7[7:0];
      default: half_cycles = HALF_W4[7:0];
    endcase
  end

  // Reserved codes 10 and 11 keep the pin idle, same as 00
  assign aux_run = (aux_clock_out_cfg == `GCL_AUXCFG_ON);

  // Aux clock divider; pin is the divider's flop
  // A rate change applies to the half period in progress, as the divider compares half_cycles live
  gcl_clk_div #(
    .CNT_W(8)
  ) u_aux_div (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(aux_run),
    .half_cycles(half_cycles),
    .clk_out(aux_clock_pin)
  );

  // Negative offset, only for the two unipolar voltage ranges
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // No shift out of reset
      offset_mv <= 10'h000;
    end else if (below_zero_shift_on && range_uni6) begin
      offset_mv <= `GCL_SHIFT6_MV;
    end else if (below_zero_shift_on && range_uni12) begin
      offset_mv <= `GCL_SHIFT12_MV;
    end else begin
      // Other ranges ignore the bit
      offset_mv <= 10'h000;
    end
  end

  // Clear routing: one-cycle pulses, one of the two per request
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // No clear pulse out of reset
      clear_immediate <= 1'b0;
      clear_slewed <= 1'b0;
    end else begin
      // Immediate path bypasses any active slew ramp
      clear_immediate <= clear_req && immediate_clear_on;
      clear_slewed <= clear_req && !immediate_clear_on;
    end
  end

  // Link error masking; flags are levels, so unmasking shows them at once
  // Raw flags still show in the status word while quieted
  assign link_err_any = link_check_err | frame_slip_err | edge_count_err;
  assign link_err_vis = link_err_any & ~link_diag_quiet_on;

  // Summary is the OR of all digital diagnostics except quieted ones
  assign next_summary = link_err_vis | (|other_diag_err);

  // Fault also carries the analog side; quieted link errors stay off
  assign next_fault = next_summary | analog_fault;

  // Summary and fault pin flops; fault pin is active low
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // Fault pin released during reset
      digital_diag_summary <= 1'b0;
      fault_pin_n <= 1'b1;
    end else begin
      digital_diag_summary <= next_summary;
      fault_pin_n <= ~next_fault;
    end
  end

  // Oscillator tick synchroniser; only the second stage is looked at
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      // Low start; a first tick edge only restarts the count
      osc_sync1 <= 1'b0;
      osc_sync2 <= 1'b0;
      osc_prev <= 1'b0;
    end else begin
      osc_sync1 <= osc_tick;
      osc_sync2 <= osc_sync1;
      osc_prev <= osc_sync2;
    end
  end

  // Idle counter: any oscillator edge restarts it
  // A tick slower than the timeout would be called a halt; size it so
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      osc_idle <= {OSC_W{1'b0}};
      osc_halted <= 1'b0;
    end else if (!osc_halt_watch_on) begin
      // Watch off: no override, counter parked
      osc_idle <= {OSC_W{1'b0}};
      osc_halted <= 1'b0;
    end else if (osc_sync2 != osc_prev) begin
      // Oscillator alive again clears the halt by itself
      osc_idle <= {OSC_W{1'b0}};
      osc_halted <= 1'b0;
    end else if (osc_idle >= OSC_LIMIT) begin
      // Counter holds, so the halt stands until an edge returns
      osc_halted <= 1'b1;
    end else begin
      osc_idle <= osc_idle + {{(OSC_W-1){1'b0}}, 1'b1};
    end
  end

  // Serial data override: fixed code while the halt stands
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sdo_force_dead <= 1'b0;
      sdo_dead_code <= 24'h000000;
    end else begin
      // Code is zero whenever the override is off
      sdo_force_dead <= osc_halted;
      sdo_dead_code <= osc_halted ? `GCL_DEAD_CODE : 24'h000000;
    end
  end

  // Config register as read; bits 15:14 and 23:22 read zero
  // Fault status bit mirrors the pin, inverted, in both words
  assign cfg_word = {2'h0, ~fault_pin_n, `GCL_ADDR_CONFIG, 2'h0,
                     temp_threshold_sel, aux_clock_out_cfg,
                     aux_clock_rate_sel, modem_path_on,
                     below_zero_shift_on, immediate_clear_on,
                     link_diag_quiet_on, osc_halt_watch_on, rsvd_low};

  // Status register: live flags the block derives
  // [23:22] zero, [21] fault pin inverted
  // [20:16] own address, [15:6] zero
  // [5] fixed code forced on serial out
  // [4] digital summary
  // [3:1] raw link errors, unmasked
  // [0] aux clock allowed to run
  // Nothing here is sticky; reads show the current cycle
  assign stat_word = {2'h0, ~fault_pin_n, `GCL_ADDR_STATUS, 10'h000,
                      sdo_force_dead, digital_diag_summary,
                      link_check_err, frame_slip_err, edge_count_err,
                      aux_run};

  // Read data valid only in the cycle after the read strobe
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 24'h000000;
    end else if (reg_rd && cfg_hit) begin
      // Config word, live fault bit included
      reg_rdata <= cfg_word;
    end else if (reg_rd && stat_hit) begin
      // Status word
      reg_rdata <= stat_word;
    end else begin
      // Unmapped reads and idle cycles give zero
      reg_rdata <= 24'h000000;
    end
  end

endmodule

// ### src/gcl_defs.vh
// Constants for the general configuration low field logic.
// Assumes a 125 MHz system clock and a 5-bit register address space.
`ifndef GCL_DEFS_VH
`define GCL_DEFS_VH

// System clock rate in kHz
`define GCL_CLK_KHZ 125000

// Register addresses
`define GCL_ADDR_CONFIG 5'h09
`define GCL_ADDR_STATUS 5'h1F

// Field positions in the configuration register
`define GCL_FAULT_STAT_BIT 21
`define GCL_REGADDR_HI 20
`define GCL_REGADDR_LO 16
`define GCL_TEMP_HI 13
`define GCL_TEMP_LO 12
`define GCL_AUXCFG_HI 11
`define GCL_AUXCFG_LO 10
`define GCL_RATE_HI 9
`define GCL_RATE_LO 7
`define GCL_MODEM_BIT 6
`define GCL_SHIFT_BIT 5
`define GCL_CLRNOW_BIT 4
`define GCL_QUIET_BIT 3
`define GCL_OSCW_BIT 2
`define GCL_RSVD_HI 1
`define GCL_RSVD_LO 0

// Reset values of the writable fields
`define GCL_RST_TEMP 2'h0
`define GCL_RST_AUXCFG 2'h0
`define GCL_RST_RATE 3'h4
`define GCL_RST_MODEM 1'h0
`define GCL_RST_SHIFT 1'h0
`define GCL_RST_CLRNOW 1'h0
`define GCL_RST_QUIET 1'h0
`define GCL_RST_OSCW 1'h1
`define GCL_RST_RSVD 2'h0

// Output configuration code that lets the aux clock run
`define GCL_AUXCFG_ON 2'h1

// Aux clock rates in kHz per select code
`define GCL_RATE0_KHZ 416
`define GCL_RATE1_KHZ 435
`define GCL_RATE2_KHZ 454
`define GCL_RATE3_KHZ 476
`define GCL_RATE4_KHZ 500
`define GCL_RATE5_KHZ 526
`define GCL_RATE6_KHZ 555
`define GCL_RATE7_KHZ 588
// Half period in system cycles, rounded to nearest
`define GCL_HALF_CYC(khz) ((`GCL_CLK_KHZ + (khz)) / (2 * (khz)))

// Negative offset magnitudes in mV
`define GCL_SHIFT6_MV 10'h12C
`define GCL_SHIFT12_MV 10'h190

// Fixed code shown on serial data out when the oscillator halts
`define GCL_DEAD_CODE 24'h07DEAD

// Oscillator halt timeout, in ns, and derived cycle count (rounded down)
`define GCL_OSC_TIMEOUT_NS 1000
`define GCL_OSC_TIMEOUT_CYC ((`GCL_OSC_TIMEOUT_NS * 125) / 1000)

`endif

// ### verification/gcl_config_tb.sv
// Self-checking bench for gcl_config.
// Assumes the host model drives the register bus.
`timescale 1ns/1ps
module gcl_config_tb;
  reg clk_sys, resetn, range_uni6, range_uni12, clear_req, analog_fault, osc_tick, osc_run;
  reg link_check_err, frame_slip_err, edge_count_err;
  reg [3:0] other_diag_err;
  wire [4:0] reg_addr;
  wire [23:0] reg_wdata, reg_rdata, sdo_dead_code;
  wire reg_wr, reg_rd, aux_clock_pin, modem_path_on, below_zero_shift_on, clear_immediate, clear_slewed;
  wire digital_diag_summary, fault_pin_n, sdo_force_dead;
  wire [9:0] offset_mv;
  wire [1:0] temp_threshold_sel;
  int n_mismatch = 0, check_count = 0, i, k, n;
  int half [8] = '{150, 144, 138, 131, 125, 119, 113, 106}; // Half periods per rate code
  reg [31:0] seed; // Random seed
  reg [31:0] rnd; // Latest random draw
  reg [13:0] d; // Config value sent
  reg rd_d = 1'b0; // Read seen last cycle
  reg [23:0] exp_q [$]; // Expected read data
  gcl_host_model i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  gcl_config #(.OSC_TIMEOUT(8)) i_dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .aux_clock_pin(aux_clock_pin), .modem_path_on(modem_path_on), .below_zero_shift_on(below_zero_shift_on),
    .offset_mv(offset_mv), .range_uni6(range_uni6), .range_uni12(range_uni12), .clear_req(clear_req),
    .clear_immediate(clear_immediate), .clear_slewed(clear_slewed), .link_check_err(link_check_err),
    .frame_slip_err(frame_slip_err), .edge_count_err(edge_count_err), .other_diag_err(other_diag_err),
    .analog_fault(analog_fault), .digital_diag_summary(digital_diag_summary), .fault_pin_n(fault_pin_n),
    .temp_threshold_sel(temp_threshold_sel), .osc_tick(osc_tick), .sdo_force_dead(sdo_force_dead),
    .sdo_dead_code(sdo_dead_code));
  // Clock, 8 ns period
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // Oscillator stand-in; stops when osc_run drops
  always @(posedge clk_sys) if (osc_run) osc_tick <= ~osc_tick;
  // Compare one count of checks
  task chk(input [23:0] got, input [23:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        n_mismatch++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Queue the expected data, then read
  task rd_exp(input [4:0] a, input [23:0] e);
    begin
      exp_q.push_back(e);
      i_host.rd(a);
    end
  endtask
  // Read data checker, oldest note first
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
  end
  // Count edges until the aux pin changes, bounded
  task wait_tog;
    reg p;
    begin
      n = 0;
      p = aux_clock_pin;
      while (aux_clock_pin === p && n < 400) begin
        @(posedge clk_sys);
        n++;
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // Watchdog
  initial begin
    #160000;
    n_mismatch++;
    give_verdict;
  end
  // Main sequence
  initial begin
    seed = 32'h688D3A9D;
    {resetn, range_uni6, range_uni12, clear_req, analog_fault, osc_tick} = 6'h00;
    {link_check_err, frame_slip_err, edge_count_err, other_diag_err} = 7'h00;
    osc_run = 1'b1;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd_exp(5'h09, 24'h090204);
    rd_exp(5'h05, 24'h000000);
    chk(aux_clock_pin, 24'h0);
    for (i = 0; i < 8; i++) begin
      d = {2'h0, 2'h1, i[2:0], 7'h04};
      i_host.wr(5'h09, {10'h000, d});
      wait_tog;
      wait_tog;
      chk(n, half[i]);
    end
    rnd = $random(seed);
    d = {rnd[1:0], 2'h2, 10'h004};
    i_host.wr(5'h09, {10'h000, d});
    rd_exp(5'h09, {3'h0, 5'h09, 2'h0, d});
    chk(temp_threshold_sel, d[13:12]);
    repeat (2) @(posedge clk_sys);
    chk(aux_clock_pin, 24'h0);
    i_host.wr(5'h09, 24'h000064);
    range_uni6 <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk({modem_path_on, below_zero_shift_on}, 24'h3);
    chk(offset_mv, 24'h12C);
    range_uni6 <= 1'b0;
    range_uni12 <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(offset_mv, 24'h190);
    range_uni12 <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(offset_mv, 24'h0);
    for (i = 0; i < 2; i++) begin
      i_host.wr(5'h09, {19'h0, i[0], 4'h4});
      clear_req <= 1'b1;
      @(posedge clk_sys);
      clear_req <= 1'b0;
      #1;
      chk({clear_immediate, clear_slewed}, i ? 24'h2 : 24'h1);
      @(posedge clk_sys);
    end
    for (k = 0; k < 3; k++) begin
      {link_check_err, frame_slip_err, edge_count_err} <= 3'h1 << k;
      i_host.wr(5'h09, 24'h00000C);
      @(posedge clk_sys);
      chk({digital_diag_summary, fault_pin_n}, 24'h1);
      i_host.wr(5'h09, 24'h000004);
      @(posedge clk_sys);
      chk({digital_diag_summary, fault_pin_n}, 24'h2);
    end
    i_host.wr(5'h09, 24'h00000C);
    rnd = $random(seed);
    other_diag_err <= rnd[3:0] | 4'h1;
    analog_fault <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({digital_diag_summary, fault_pin_n}, 24'h2);
    rd_exp(5'h1F, 24'h3F0018);
    {link_check_err, frame_slip_err, edge_count_err, other_diag_err, analog_fault} <= 8'h00;
    osc_run <= 1'b0;
    n = 0;
    while (sdo_force_dead !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk(sdo_force_dead, 24'h1);
    chk(sdo_dead_code, 24'h07DEAD);
    osc_run <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk(sdo_force_dead, 24'h0);
    i_host.wr(5'h09, 24'h000000);
    osc_run <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk(sdo_force_dead, 24'h0);
    give_verdict;
  end
endmodule

// ### verification/gcl_host_model.sv
// Host model: register bus master with one-cycle strobes.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/1ps
module gcl_host_model (
  // Clock
  input wire clk_sys,
  // Register bus
  output reg [4:0] reg_addr,
  output reg [23:0] reg_wdata,
  output reg reg_wr,
  output reg reg_rd
);
  // Idle bus at time zero
  initial begin
    reg_addr = 5'h00;
    reg_wdata = 24'h000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Write; a gap edge follows so strobes never double-assign
  task wr(input [4:0] a, input [23:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= {d[23:2], 2'h0};
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_wdata <= ~{d[23:2], 2'h0}; // Stale data not left on bus
      @(posedge clk_sys);
    end
  endtask
  // Read; data is taken by the bench one cycle later
  task rd(input [4:0] a);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
endmodule

// ### verification/gcl_monitor.sv
// Port checker for gcl_config.
// Assumes it is bound into every gcl_config instance.
`timescale 1ns/1ps
module gcl_monitor #(
  parameter OTHER_W = 4
) (
  // Clock, reset and bus
  input wire clk_sys,
  input wire resetn,
  input wire [4:0] reg_addr,
  input wire [23:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [23:0] reg_rdata,
  // Watched pins
  input wire aux_clock_pin,
  input wire modem_path_on,
  input wire [9:0] offset_mv,
  input wire range_uni6,
  input wire clear_req,
  input wire clear_immediate,
  input wire clear_slewed,
  input wire link_check_err,
  input wire frame_slip_err,
  input wire edge_count_err,
  input wire [OTHER_W-1:0] other_diag_err,
  input wire analog_fault,
  input wire digital_diag_summary,
  input wire fault_pin_n,
  input wire sdo_force_dead,
  input wire [23:0] sdo_dead_code
);
  reg [13:0] cfg; // Mirror of the writable config bits
  wire link_any = link_check_err | frame_slip_err | edge_count_err; // Any link error
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Mirror follows host writes to the config address
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg <= 14'h0204;
    end else if (reg_wr && reg_addr == 5'h09) begin
      cfg <= reg_wdata[13:0];
    end
  end
  AST_AUX_IDLE: assert property (cfg[11:10] != 2'h1 |=> !aux_clock_pin)
    else $error("aux clock not idle");
  AST_MODEM: assert property ($past(cfg[6]) == cfg[6] |-> modem_path_on == cfg[6])
    else $error("path select wrong");
  AST_OFS6: assert property (cfg[5] && range_uni6 |=> offset_mv == 10'h12C)
    else $error("offset not 300");
  AST_OFS_OFF: assert property (!cfg[5] |=> offset_mv == 10'h000)
    else $error("offset without shift");
  AST_CLR_NOW: assert property (clear_req && cfg[4] |=> clear_immediate && !clear_slewed)
    else $error("clear not immediate");
  AST_CLR_SLEW: assert property (clear_req && !cfg[4] |=> clear_slewed && !clear_immediate)
    else $error("clear not slewed");
  AST_QUIET_SUM: assert property (cfg[3] && other_diag_err == 0 |=> !digital_diag_summary)
    else $error("quiet summary set");
  AST_QUIET_FAULT: assert property (cfg[3] && other_diag_err == 0 && !analog_fault |=> fault_pin_n)
    else $error("quiet fault pin low");
  AST_UNQUIET: assert property (!cfg[3] && link_any |=> digital_diag_summary && !fault_pin_n)
    else $error("link error hidden");
  AST_DEAD: assert property (sdo_force_dead |-> sdo_dead_code == 24'h07DEAD)
    else $error("halt code wrong");
  AST_WATCH_OFF: assert property (!cfg[2] [*2] |=> !sdo_force_dead)
    else $error("halt shown while unwatched");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 24'h000000)
    else $error("read data not cleared");
endmodule
bind gcl_config gcl_monitor #(.OTHER_W(OTHER_W)) i_mon (.clk_sys(clk_sys), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .aux_clock_pin(aux_clock_pin), .modem_path_on(modem_path_on), .offset_mv(offset_mv),
  .range_uni6(range_uni6), .clear_req(clear_req), .clear_immediate(clear_immediate),
  .clear_slewed(clear_slewed), .link_check_err(link_check_err), .frame_slip_err(frame_slip_err),
  .edge_count_err(edge_count_err), .other_diag_err(other_diag_err), .analog_fault(analog_fault),
  .digital_diag_summary(digital_diag_summary), .fault_pin_n(fault_pin_n),
  .sdo_force_dead(sdo_force_dead), .sdo_dead_code(sdo_dead_code));
